// file: rtl/spc2_top.sv
// serial port second control register, pin ownership, break and idle queueing
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "spc2_cfg.svh"
module spc2_top
    import spc2_pkg::*;
(
    // clock and reset
    input  wire logic           hclk,
    input  wire logic           hresetn,
    // ahb-lite slave
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output logic                hreadyout,
    output logic                hresp,
    output logic [31:0]         hrdata,
    // rest of the port
    input  wire spc2_flags_type flags,
    input  wire spc2_mode_type  mode,
    input  wire logic           bit_tick,
    input  wire logic           tx_data_busy,
    input  wire logic           tx_data_bit,
    input  wire logic           rx_idle_detect,
    input  wire logic           rx_char_done,
    input  wire logic           rx_msb_bit,
    // to rest of the port
    output logic                tx_irq_req,
    output logic                rx_irq_req,
    output logic                transmitter_on,
    output logic                receiver_on,
    output logic                receiver_standby,
    output logic                rx_serial_in,
    // transmit pin
    input  wire logic           txd_in,
    output logic                txd_out,
    output logic                txd_oe,
    // receive pin
    input  wire logic           rxd_in,
    output logic                rxd_owned
);

    spc2_ctrl_type  ctrl_reg;
    spc2_ctrl_type  ctrl_next;
    spc2_state_type state_reg;
    spc2_state_type state_next;
    logic [3:0]     bit_cnt_reg;
    logic [3:0]     bit_cnt_next;
    logic           brk_pend_reg;
    logic           idle_pend_reg;
    logic           dph_wr_reg;
    logic [5:0]     dph_idx_reg;
    logic [31:0]    rdata_reg;
    logic           aph_take;
    logic           ctrl_wr;
    logic [5:0]     aph_idx;
    logic           te_rise;
    logic           sbk_rise;
    logic           brk_start;
    logic           pre_start;
    logic           char_end;
    logic [3:0]     char_len;
    logic           wake_hit;
    logic           tx_line;
    logic           tx_owns_pin;
    logic           single_wire;
    logic [7:0]     status_byte;
    logic [1:0]     pin_raw;
    logic [1:0]     pin_s1_reg;
    logic [1:0]     pin_s2_reg;
    logic [1:0]     pin_s3_reg;
    logic [1:0]     pin_filt_reg;

    // bus answers at once, never errors
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;

    assign aph_take = hsel & htrans[1] & hready;
    assign aph_idx  = haddr[`SPC2_ADDR_MSB:`SPC2_ADDR_LSB];
    assign ctrl_wr  = dph_wr_reg & (dph_idx_reg == `SPC2_IDX_CTRL);

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_reg  <= 1'b0;
            dph_idx_reg <= `SPC2_IDX_CTRL;
        end else begin
            dph_wr_reg  <= aph_take & hwrite;
            dph_idx_reg <= aph_idx;
        end
    end

    // control register next value: software writes, hardware clears standby
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wake_hit) begin
            ctrl_next.receiver_standby = 1'b0;
        end
        if (ctrl_wr) begin
            ctrl_next = spc2_ctrl_type'(hwdata[7:0]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= spc2_ctrl_type'(`SPC2_CTRL_RESET);
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // read data, forwarded from a write in the same cycle
    // so a read right behind a write already returns the new value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= `SPC2_ZERO32;
        end else if (aph_take && !hwrite) begin
            unique case (aph_idx)
                `SPC2_IDX_CTRL:   rdata_reg <= {24'h00_0000, ctrl_next};
                `SPC2_IDX_STATUS: rdata_reg <= {24'h00_0000, status_byte};
                default:          rdata_reg <= `SPC2_ZERO32;
            endcase
        end
    end

    // interrupt requests, level while any enabled flag is set
    assign tx_irq_req = (ctrl_reg.tx_empty_irq_en & flags.tx_buffer_empty_flag)
                      | (ctrl_reg.tx_complete_irq_en & flags.tx_complete_flag);
    assign rx_irq_req = (ctrl_reg.rx_full_irq_en & flags.rx_buffer_full_flag)
                      | (ctrl_reg.idle_line_irq_en & flags.idle_line_flag);

    // edges of software writes, written value against the old one
    // so that rewriting the same value queues nothing new
    assign te_rise  = ctrl_wr & ctrl_next.transmitter_enable & ~ctrl_reg.transmitter_enable;
    assign sbk_rise = ctrl_wr & ctrl_next.send_break_request & ~ctrl_reg.send_break_request;

    // character length in bit times, less one: the last value of the bit counter
    always_comb begin
        if (state_reg == SPC2_ST_BREAK) begin
            if (mode.long_break_select) begin
                char_len = mode.char_9bit ? `SPC2_LEN_LBRK9 : `SPC2_LEN_LBRK8;
            end else begin
                char_len = mode.char_9bit ? `SPC2_LEN_BRK9 : `SPC2_LEN_BRK8;
            end
        end else begin
            char_len = mode.char_9bit ? `SPC2_LEN_IDLE9 : `SPC2_LEN_IDLE8;
        end
    end

    assign char_end  = bit_tick & (bit_cnt_reg == char_len);
    assign brk_start = (state_reg == SPC2_ST_IDLE) & ~tx_data_busy & brk_pend_reg;
    assign pre_start = (state_reg == SPC2_ST_IDLE) & ~tx_data_busy & ~brk_pend_reg
                     & idle_pend_reg;

    // transmit sequencer: data first, then break, then idle
    always_comb begin
        state_next   = state_reg;
        bit_cnt_next = bit_cnt_reg;
        unique case (state_reg)
            SPC2_ST_IDLE: begin
                bit_cnt_next = `SPC2_CNT_ZERO;
                if (tx_data_busy && ctrl_reg.transmitter_enable) begin
                    state_next = SPC2_ST_DATA;
                end else if (brk_start) begin
                    state_next = SPC2_ST_BREAK;
                end else if (pre_start) begin
                    state_next = SPC2_ST_PRE;
                end
            end
            SPC2_ST_DATA: begin
                if (!tx_data_busy) begin
                    state_next = SPC2_ST_IDLE;
                end
            end
            SPC2_ST_BREAK, SPC2_ST_PRE: begin
                if (char_end) begin
                    state_next   = SPC2_ST_IDLE;
                    bit_cnt_next = `SPC2_CNT_ZERO;
                end else if (bit_tick) begin
                    bit_cnt_next = bit_cnt_reg + `SPC2_CNT_ONE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg   <= SPC2_ST_IDLE;
            bit_cnt_reg <= `SPC2_CNT_ZERO;
        end else begin
            state_reg   <= state_next;
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // break queue: set on send-break rise while the transmitter is enabled, or end of a break while held
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brk_pend_reg <= 1'b0;
        end else if ((sbk_rise && ctrl_reg.transmitter_enable)
                  || ((state_reg == SPC2_ST_BREAK) && char_end
                      && ctrl_reg.send_break_request)) begin
            brk_pend_reg <= 1'b1;
        end else if (brk_start) begin
            brk_pend_reg <= 1'b0;
        end
    end

    // idle queue: set when the enable goes from zero to one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_pend_reg <= 1'b0;
        end else if (te_rise) begin
            idle_pend_reg <= 1'b1;
        end else if (pre_start) begin
            idle_pend_reg <= 1'b0;
        end
    end

    // transmit pin ownership and level
    assign tx_owns_pin = ctrl_reg.transmitter_enable | (state_reg != SPC2_ST_IDLE)
                       | brk_pend_reg | idle_pend_reg;
    assign single_wire = mode.loop_select & mode.receiver_source_select;

    always_comb begin
        unique case (state_reg)
            SPC2_ST_BREAK: tx_line = 1'b0;
            SPC2_ST_DATA:  tx_line = tx_data_bit;
            default:       tx_line = 1'b1;
        endcase
    end

    assign transmitter_on = tx_owns_pin;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txd_out <= 1'b1;
            txd_oe  <= 1'b0;
        end else begin
            txd_out <= tx_line;
            txd_oe  <= tx_owns_pin & (~single_wire | mode.single_wire_direction);
        end
    end

    // pin synchronisers: change taken when second and third stages agree
    // stages reset to the idle line level so no false edge follows reset
    assign pin_raw = {txd_in, rxd_in};

    genvar gi;
    generate
        for (gi = 0; gi < `SPC2_PINS; gi = gi + 1) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pin_s1_reg[gi]   <= 1'b1;
                    pin_s2_reg[gi]   <= 1'b1;
                    pin_s3_reg[gi]   <= 1'b1;
                    pin_filt_reg[gi] <= 1'b1;
                end else begin
                    pin_s1_reg[gi] <= pin_raw[gi];
                    pin_s2_reg[gi] <= pin_s1_reg[gi];
                    pin_s3_reg[gi] <= pin_s2_reg[gi];
                    if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
                        pin_filt_reg[gi] <= pin_s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    // receiver source and receive pin release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_serial_in <= 1'b1;
        end else if (!mode.loop_select) begin
            rx_serial_in <= pin_filt_reg[0];
        end else if (mode.receiver_source_select) begin
            rx_serial_in <= pin_filt_reg[1];
        end else begin
            rx_serial_in <= tx_line;
        end
    end

    assign rxd_owned   = ctrl_reg.receiver_enable & ~mode.loop_select;
    assign receiver_on = ctrl_reg.receiver_enable;

    // standby wakeup detection
    assign wake_hit = ctrl_reg.receiver_standby & ctrl_reg.receiver_enable
                    & (mode.wake_address_mark ? (rx_char_done & rx_msb_bit)
                                              : rx_idle_detect);
    assign receiver_standby = ctrl_reg.receiver_standby;

    // own status readback
    assign status_byte = {rx_irq_req, tx_irq_req, state_reg, idle_pend_reg,
                          brk_pend_reg, rxd_owned, tx_owns_pin};

endmodule

// file: rtl/spc2_cfg.svh
// constants for the serial port second control block
`ifndef SPC2_CFG_SVH
`define SPC2_CFG_SVH
`define SPC2_ADDR_LSB      2
`define SPC2_ADDR_MSB      7
`define SPC2_IDX_CTRL      6'h00
`define SPC2_IDX_STATUS    6'h01
`define SPC2_CTRL_RESET    8'h00
`define SPC2_ZERO32        32'h0000_0000
`define SPC2_LEN_IDLE8     4'h9
`define SPC2_LEN_IDLE9     4'ha
`define SPC2_LEN_BRK8      4'h9
`define SPC2_LEN_BRK9      4'ha
`define SPC2_LEN_LBRK8     4'hc
`define SPC2_LEN_LBRK9     4'hd
`define SPC2_CNT_ZERO      4'h0
`define SPC2_CNT_ONE       4'h1
`define SPC2_PINS          2
`endif

// file: rtl/spc2_pkg.sv
// types shared by the serial port second control block
package spc2_pkg;
    typedef struct packed {
        logic tx_empty_irq_en;
        logic tx_complete_irq_en;
        logic rx_full_irq_en;
        logic idle_line_irq_en;
        logic transmitter_enable;
        logic receiver_enable;
        logic receiver_standby;
        logic send_break_request;
    } spc2_ctrl_type;

    typedef struct packed {
        logic loop_select;
        logic receiver_source_select;
        logic single_wire_direction;
        logic wake_address_mark;
        logic long_break_select;
        logic char_9bit;
    } spc2_mode_type;

    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic tx_complete_flag;
        logic rx_buffer_full_flag;
        logic idle_line_flag;
    } spc2_flags_type;

    typedef enum logic [1:0] {
        SPC2_ST_IDLE  = 2'b00,
        SPC2_ST_DATA  = 2'b01,
        SPC2_ST_BREAK = 2'b11,
        SPC2_ST_PRE   = 2'b10
    } spc2_state_type;
endpackage

// file: test/spc2_top_chk.sv
// assertion checker for the serial port control block
`timescale 1ns/1ps
module spc2_chk
    import spc2_pkg::*;
(
    // bus
    input wire logic           hclk,
    input wire logic           hresetn,
    input wire logic           hsel,
    input wire logic [31:0]    haddr,
    input wire logic [1:0]     htrans,
    input wire logic           hwrite,
    input wire logic [31:0]    hwdata,
    input wire logic           hready,
    input wire logic           hreadyout,
    input wire logic           hresp,
    input wire logic [31:0]    hrdata,
    // port side
    input wire spc2_flags_type flags,
    input wire spc2_mode_type  mode,
    input wire logic           rx_idle_detect,
    input wire logic           rx_char_done,
    input wire logic           rx_msb_bit,
    input wire logic           tx_irq_req,
    input wire logic           rx_irq_req,
    input wire logic           transmitter_on,
    input wire logic           receiver_on,
    input wire logic           receiver_standby,
    input wire logic           txd_oe,
    input wire logic           rxd_owned
);
    logic       wr_reg;
    logic       rd_reg;
    logic [7:0] ctl_reg;
    logic       wake;
    assign wake = receiver_standby && receiver_on &&
        (mode.wake_address_mark ? rx_char_done && rx_msb_bit : rx_idle_detect);
    // tracks control writes and reads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else if (hready) begin
            wr_reg <= hsel && htrans[1] && hwrite && haddr[7:2] == 6'h00;
            rd_reg <= hsel && htrans[1] && !hwrite && haddr[7:2] == 6'h00;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_reg <= 8'h00;
        end else if (wr_reg) begin
            ctl_reg <= hwdata[7:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_tx_irq_map: assert property (
        tx_irq_req == (ctl_reg[7] & flags.tx_buffer_empty_flag | ctl_reg[6] & flags.tx_complete_flag))
        else $error("tx irq wrong");
    a_rx_irq_map: assert property (
        rx_irq_req == (ctl_reg[5] & flags.rx_buffer_full_flag | ctl_reg[4] & flags.idle_line_flag))
        else $error("rx irq wrong");
    a_rx_pin_own: assert property (rxd_owned == (ctl_reg[2] && !mode.loop_select))
        else $error("rx pin owner wrong");
    a_rx_enable: assert property (receiver_on == ctl_reg[2])
        else $error("receiver on wrong");
    a_tx_keep: assert property (ctl_reg[3] |-> transmitter_on)
        else $error("tx pin not owned");
    a_tx_drive: assert property (transmitter_on && !mode.loop_select |=> txd_oe)
        else $error("tx pin not driven");
    a_wire_dir: assert property (
        transmitter_on && mode.loop_select && mode.receiver_source_select
        |=> txd_oe == $past(mode.single_wire_direction))
        else $error("single wire direction wrong");
    a_tx_release: assert property (!transmitter_on |=> !txd_oe)
        else $error("tx pin not released");
    a_wake_clear: assert property (wake && !wr_reg |=> !receiver_standby)
        else $error("standby not cleared");
    a_standby_hold: assert property (
        receiver_standby && !wake && !wr_reg |=> receiver_standby)
        else $error("standby lost");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus response wrong");
    a_ctrl_read: assert property (
        rd_reg |-> hrdata == {24'h00_0000, ctl_reg[7:2], receiver_standby, ctl_reg[0]})
        else $error("control read wrong");
endmodule
bind spc2_top spc2_chk chk_u (.*);

// file: test/spc2_peer.sv
// remote serial peer: resolves the transmit line and times low spans
`timescale 1ns/1ps
module spc2_peer (
    // clock
    input wire logic   hclk,
    // line side
    input wire logic   txd_out,
    input wire logic   txd_oe,
    input wire logic   peer_bit,
    output logic       txd_in,
    output logic       rxd_in,
    // break timing
    output logic [7:0] low_cycles,
    output logic [7:0] brk_count
);
    logic [7:0] run_cnt;
    // a released line shows the peer's own changing level
    assign txd_in = txd_oe ? txd_out : peer_bit;
    assign rxd_in = peer_bit;
    initial begin
        run_cnt = 8'h00;
        low_cycles = 8'h00;
        brk_count = 8'h00;
    end
    always @(posedge hclk) begin
        if (txd_oe && !txd_out) begin
            run_cnt <= run_cnt + 8'h01;
        end else if (run_cnt != 8'h00) begin
            low_cycles <= run_cnt;
            brk_count <= brk_count + 8'h01;
            run_cnt <= 8'h00;
        end
    end
endmodule

// file: test/serial_port_control_two_test.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module serial_port_control_two_test
    import spc2_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, bit_tick, tx_data_busy;
    logic tx_data_bit, rx_idle_detect, rx_char_done, rx_msb_bit, tx_irq_req, rx_irq_req;
    logic transmitter_on, receiver_on, receiver_standby, rx_serial_in, peer_bit;
    logic txd_in, txd_out, txd_oe, rxd_in, rxd_owned;
    logic [31:0]    haddr, hwdata, hrdata, rd;
    logic [2:0]     hsize;
    logic [1:0]     htrans, tc;
    logic [7:0]     low_cycles, brk_count, b0;
    logic [3:0]     en;
    spc2_flags_type flags;
    spc2_mode_type  mode;
    int             n_errors, samples_checked, i;
    int             seed = 32'hb250;
    assign hready = hreadyout;
    spc2_top dut_u (.*);
    spc2_peer peer_u (.*);
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        tc <= tc + 2'd1;
        bit_tick <= (tc == 2'd3);
        peer_bit <= 1'($random(seed));
        tx_data_bit <= 1'($random(seed));
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        #1;
    endtask
    task automatic wait_brk(input logic [7:0] n);
        int w = 0;
        while (brk_count !== n && w < 3000) begin
            cyc(1);
            w++;
        end
        check("brk_wait", brk_count, n);
    endtask
    function automatic logic [1:0] irq_exp(input logic [3:0] e, input spc2_flags_type f);
        return {e[3] & f.tx_buffer_empty_flag | e[2] & f.tx_complete_flag,
                e[1] & f.rx_buffer_full_flag | e[0] & f.idle_line_flag};
    endfunction
    task automatic finish_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #200_000;
        n_errors++;
        finish_test();
    end
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, tx_data_busy, rx_idle_detect, rx_char_done, rx_msb_bit} = '0;
        {bit_tick, tx_data_bit, peer_bit, haddr, hwdata, htrans, flags, mode, tc} = '0;
        hsize = 3'b010;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        bus(1'b0, 8'h00, 0);
        check("ctrl_reset", rd, 32'h0000_0000);
        check("pins_reset", {txd_oe, rxd_owned, transmitter_on}, 3'b000);
        bus(1'b0, 8'h08, 0);
        check("unmapped", rd, 32'h0000_0000);
        for (i = 0; i < 24; i++) begin
            en = (i == 0) ? 4'hf : 4'($random(seed));
            flags <= 4'($random(seed));
            bus(1'b1, 8'h00, {24'h00_0000, en, 4'h0});
            check("irq", {tx_irq_req, rx_irq_req}, irq_exp(en, flags));
            bus(1'b0, 8'h00, 0);
            check("ctrl_rw", rd, {24'h00_0000, en, 4'h0});
        end
        bus(1'b1, 8'h00, 32'h0000_0004);
        for (i = 0; i < 2; i++) begin
            mode <= {i[0], 5'b00000};
            cyc(1);
            check("rx_owned", {receiver_on, rxd_owned}, {1'b1, !i[0]});
        end
        for (i = 0; i < 2; i++) begin
            mode <= {3'b000, i[0], 2'b00};
            bus(1'b1, 8'h00, 32'h0000_0006);
            check("standby_set", receiver_standby, 1'b1);
            {rx_char_done, rx_msb_bit, rx_idle_detect} <= {!i[0], !i[0], i[0]};
            cyc(1);
            {rx_char_done, rx_idle_detect} <= 2'b00;
            cyc(1);
            check("standby_hold", receiver_standby, 1'b1);
            {rx_char_done, rx_msb_bit, rx_idle_detect} <= {i[0], 1'b1, !i[0]};
            cyc(1);
            {rx_char_done, rx_idle_detect} <= 2'b00;
            cyc(1);
            check("standby_wake", receiver_standby, 1'b0);
        end
        bus(1'b1, 8'h00, 32'h0000_0008);
        for (i = 0; i < 4; i++) begin
            mode <= {4'b0000, i[1:0]};
            b0 = brk_count;
            bus(1'b1, 8'h00, 32'h0000_0009);
            bus(1'b1, 8'h00, 32'h0000_0008);
            wait_brk(b0 + 8'd1);
            check("break_len", (low_cycles + 8'd3) >> 2, 8'd10 + i[0] + 3 * i[1]);
            cyc(80);
            check("break_once", brk_count, b0 + 8'd1);
        end
        mode <= {3'b111, 3'b000};
        b0 = brk_count;
        bus(1'b1, 8'h00, 32'h0000_0009);
        wait_brk(b0 + 8'd2);
        check("break_repeat", brk_count, b0 + 8'd2);
        cyc(10);
        check("wire_rx", rx_serial_in, 1'b0);
        bus(1'b1, 8'h00, 32'h0000_0000);
        check("tx_drain", transmitter_on, 1'b1);
        wait_brk(b0 + 8'd3);
        cyc(60);
        check("tx_release", {transmitter_on, txd_oe}, 2'b00);
        mode <= 6'h00;
        bus(1'b1, 8'h00, 32'h0000_0008);
        cyc(60);
        bus(1'b0, 8'h04, 0);
        check("idle_done", rd[5:2], 4'b0000);
        tx_data_busy <= 1'b1;
        cyc(60);
        bus(1'b1, 8'h00, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h0000_0008);
        bus(1'b0, 8'h04, 0);
        check("idle_queued", rd[5:3], 3'b011);
        tx_data_busy <= 1'b0;
        cyc(4);
        bus(1'b0, 8'h04, 0);
        check("idle_char", rd[5:4], 2'b10);
        for (i = 0; i < 2; i++) begin
            mode <= {2'b11, i[0], 3'b000};
            cyc(2);
            check("wire_dir", txd_oe, i[0]);
        end
        finish_test();
    end
endmodule
